// [core/lpmc_consts.vh]
`ifndef LPMC_CONSTS_VH
`define LPMC_CONSTS_VH

// AXI4-Lite register byte offsets
`define LPMC_CTRL_OFS 4'h0
`define LPMC_STAT_OFS 4'h4
`define LPMC_VEC_OFS 4'h8

// Control register field positions
`define LPMC_CTRL_OSC_LO 0
`define LPMC_CTRL_OSC_HI 1
`define LPMC_CTRL_HALT_OPT 2
`define LPMC_CTRL_PORT_OPT 3
`define LPMC_CTRL_LONG_DLY 4

// Control register reset value: internal oscillator selected
`define LPMC_CTRL_RST 5'h02

// Wake vectors (address of the high byte of each pair)
`define LPMC_VEC_RESET 16'h1ffe
`define LPMC_VEC_EXT 16'h1ffa
`define LPMC_VEC_CTICK 16'h1ff8
`define LPMC_VEC_PTMR 16'h1ff6
`define LPMC_VEC_SERIAL 16'h1ff4
`define LPMC_VEC_ANALOG 16'h1ff2

// Recovery delays in internal bus cycles
`define LPMC_DLY_SHORT 12'd16
`define LPMC_DLY_LONG 12'd4064

`endif

// [core/lpmc_top.v]
`timescale 1ns/1ns
`include "lpmc_consts.vh"

// Overview of operation
// - Stop halts both oscillators; oscillator-select bits keep their values
// - While stopped, watchdog, timers, analog and serial get no clock
// - Stop entry clears core tick flags and their interrupt enables
// - Stop entry clears programmable timer flags and interrupt enables
// - Stop entry sets external irq enable, clears mask; port pins optional
// - Stop entry changes nothing beyond the listed effects
// - External pin falling edge ends stop, vector external pair
// - Option-enabled port pin rising edge ends stop, external vector
// - Low reset pin ends stop, resets device, reset vector
// - Stop exit waits 16 or 4064 bus cycles per delay option
// - Wait clears interrupt mask, sets external irq enable, nothing else
// - Wait stops only the bus clock; peripherals keep clocking
// - In wait, external or port edge restarts bus clock, external vector
// - In wait, core tick overflow or periodic tick wakes, core tick vector
// - In wait, programmable timer interrupt wakes, timer vector
// - In wait, serial transfer-complete interrupt wakes, serial vector
// - In wait, analog comparison interrupt wakes, analog vector
// - In wait, watchdog timeout or reset pin resets, reset vector
// - Wait exit resumes with no recovery delay
// - Halt option: stop acts as wait, then 1..16 or 1..4064 delay
// - Halt option keeps watchdog running since oscillators keep running
// - Oscillator select: 00/10 internal, 01 external, 11 both internal
module lpmc_top (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Core instruction requests and acknowledges
	input wire stop_req_in,
	input wire wait_req_in,
	output wire cpu_clk_en_out,
	output reg resume_out,
	output reg [15:0] vector_out,
	output reg cpu_reset_out,
	output reg irq_mask_clr_out,
	// Wake sources
	input wire ext_irq_pin_in,
	input wire reset_pin_in,
	input wire [3:0] wake_port_pins_in,
	input wire core_tick_irq_in,
	input wire prog_timer_irq_in,
	input wire serial_irq_in,
	input wire analog_irq_in,
	input wire watchdog_timeout_in,
	// Peripheral bit controls
	output reg core_tick_clr_out,
	output reg prog_timer_clr_out,
	output reg ext_irq_enable_set_out,
	// Clock gating
	output wire internal_slow_osc_en_out,
	output wire external_pin_osc_en_out,
	output wire osc_use_external_out,
	output wire periph_clk_en_out,
	output wire watchdog_clk_en_out,
	output wire port_wake_en_out,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	localparam ST_RUN = 2'd0;
	localparam ST_STOP = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_RECOV = 2'd3;

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [11:0] dly_reg;
	reg [11:0] dly_next;
	reg halt_mode_reg;
	reg [4:0] ctrl_reg;
	reg [15:0] pend_vec_reg;
	reg [2:0] irq_sync_reg;
	reg [2:0] rst_sync_reg;
	reg [11:0] port_sync_reg;
	reg irq_lvl_reg;
	reg [3:0] port_lvl_reg;
	reg [11:0] free_cnt_reg;
	reg aw_hold_reg;
	reg w_hold_reg;
	reg [3:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	wire osc_lo = ctrl_reg[`LPMC_CTRL_OSC_LO];
	wire osc_hi = ctrl_reg[`LPMC_CTRL_OSC_HI];
	wire halt_opt = ctrl_reg[`LPMC_CTRL_HALT_OPT];
	wire port_opt = ctrl_reg[`LPMC_CTRL_PORT_OPT];
	wire long_dly = ctrl_reg[`LPMC_CTRL_LONG_DLY];

	// Synchronised external pins: stages 2 and 3 must agree
	// A pin level only counts once both late stages hold it, and an
	// edge is a change of that agreed level, so a glitch that never
	// reaches agreement does not wake the part
	wire irq_agree = irq_sync_reg[2] == irq_sync_reg[1];
	wire irq_fall = irq_agree & irq_lvl_reg & ~irq_sync_reg[2];
	wire rst_low = ~rst_sync_reg[2] & ~rst_sync_reg[1];
	wire [3:0] port_rise;
	wire [3:0] port_lvl_next;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_port
			// Rising edge once stages 2 and 3 agree on a new high
			assign port_rise[gi] = port_sync_reg[8 + gi] &&
				port_sync_reg[4 + gi] && !port_lvl_reg[gi];
			// Agreed level follows the pin only when the stages match
			assign port_lvl_next[gi] =
				port_sync_reg[8 + gi] == port_sync_reg[4 + gi] ?
				port_sync_reg[8 + gi] : port_lvl_reg[gi];
		end
	endgenerate

	wire ext_wake = irq_fall | (port_opt & (|port_rise));
	// Halt keeps the oscillators alive, so only a true stop gates
	// the peripheral and watchdog clocks
	wire true_stop = state_reg == ST_STOP && !halt_mode_reg;
	wire asleep = state_reg == ST_STOP || state_reg == ST_WAIT;
	wire [11:0] max_dly = long_dly ? `LPMC_DLY_LONG : `LPMC_DLY_SHORT;
	// Peripheral interrupts that wake from wait, and from halt
	wire irq_wake = core_tick_irq_in | prog_timer_irq_in | serial_irq_in |
		analog_irq_in;

	// Wake vector by fixed priority: external pins first, then core
	// tick, programmable timer, serial and analog
	reg [15:0] wake_vec;
	always @* begin
		if (ext_wake) begin
			wake_vec = `LPMC_VEC_EXT;
		end else if (core_tick_irq_in) begin
			wake_vec = `LPMC_VEC_CTICK;
		end else if (prog_timer_irq_in) begin
			wake_vec = `LPMC_VEC_PTMR;
		end else if (serial_irq_in) begin
			wake_vec = `LPMC_VEC_SERIAL;
		end else begin
			wake_vec = `LPMC_VEC_ANALOG;
		end
	end

	// Oscillator selection; true stop kills both
	assign internal_slow_osc_en_out = ~(~osc_hi & osc_lo) & ~true_stop;
	assign external_pin_osc_en_out = osc_lo & ~true_stop;
	assign osc_use_external_out = ~osc_hi & osc_lo;
	assign periph_clk_en_out = ~true_stop;
	assign watchdog_clk_en_out = ~true_stop;
	assign cpu_clk_en_out = state_reg == ST_RUN;
	assign port_wake_en_out = port_opt;

	// Three-flop synchronisers for pins
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_sync_reg <= 3'h7;
			rst_sync_reg <= 3'h7;
			port_sync_reg <= 12'h000;
			irq_lvl_reg <= 1'b1;
			port_lvl_reg <= 4'h0;
		end else begin
			irq_sync_reg <= {irq_sync_reg[1:0], ext_irq_pin_in};
			rst_sync_reg <= {rst_sync_reg[1:0], reset_pin_in};
			port_sync_reg <= {port_sync_reg[7:0], wake_port_pins_in};
			if (irq_agree) begin
				irq_lvl_reg <= irq_sync_reg[2];
			end
			port_lvl_reg <= port_lvl_next;
		end
	end

	// Free-running count gives the variable halt recovery
	// The wake edge is unrelated to this count, so the delay picked
	// from it lands anywhere in the allowed range
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			free_cnt_reg <= 12'h000;
		end else begin
			free_cnt_reg <= free_cnt_reg + 12'h001;
		end
	end

	// Mode sequencer next state
	always @* begin
		state_next = state_reg;
		dly_next = dly_reg;
		case (state_reg)
			ST_RUN: begin
				if (stop_req_in) begin
					state_next = ST_STOP;
				end else if (wait_req_in) begin
					state_next = ST_WAIT;
				end
			end
			ST_STOP: begin
				// True stop hears only the external pins, as peripheral
				// clocks are off; halt also takes the wait sources
				if (ext_wake || (halt_mode_reg && irq_wake)) begin
					state_next = ST_RECOV;
					if (halt_mode_reg) begin
						// Halt: 1..max cycles, phase-dependent
						dly_next = (free_cnt_reg % max_dly) + 12'h001;
					end else begin
						dly_next = max_dly;
					end
				end
			end
			ST_WAIT: begin
				if (ext_wake || core_tick_irq_in || prog_timer_irq_in ||
					serial_irq_in || analog_irq_in) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				if (dly_reg <= 12'h001) begin
					state_next = ST_RUN;
				end else begin
					dly_next = dly_reg - 12'h001;
				end
			end
		endcase
	end

	// Sequencer registers and core-facing pulses
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= ST_RUN;
			dly_reg <= 12'h000;
			halt_mode_reg <= 1'b0;
			pend_vec_reg <= `LPMC_VEC_RESET;
			vector_out <= `LPMC_VEC_RESET;
			resume_out <= 1'b0;
			cpu_reset_out <= 1'b0;
			irq_mask_clr_out <= 1'b0;
			core_tick_clr_out <= 1'b0;
			prog_timer_clr_out <= 1'b0;
			ext_irq_enable_set_out <= 1'b0;
		end else begin
			resume_out <= 1'b0;
			cpu_reset_out <= 1'b0;
			irq_mask_clr_out <= 1'b0;
			core_tick_clr_out <= 1'b0;
			prog_timer_clr_out <= 1'b0;
			ext_irq_enable_set_out <= 1'b0;
			if (rst_low || (asleep && watchdog_timeout_in && !true_stop)) begin
				// Reset pin, or watchdog in wait or halt. The core is held in
				// reset each cycle the pin stays low, but resume fires
				// only when leaving stop, wait or recovery, so it fetches once
				state_reg <= ST_RUN;
				dly_reg <= 12'h000;
				halt_mode_reg <= 1'b0;
				pend_vec_reg <= `LPMC_VEC_RESET;
				cpu_reset_out <= 1'b1;
				vector_out <= `LPMC_VEC_RESET;
				resume_out <= state_reg != ST_RUN;
			end else begin
				state_reg <= state_next;
				dly_reg <= dly_next;
				if (state_reg == ST_RUN && (stop_req_in || wait_req_in)) begin
					// Only the listed bits change on entry
					irq_mask_clr_out <= 1'b1;
					ext_irq_enable_set_out <= 1'b1;
					halt_mode_reg <= stop_req_in & halt_opt;
					core_tick_clr_out <= stop_req_in & ~halt_opt;
					prog_timer_clr_out <= stop_req_in & ~halt_opt;
				end
				if (state_reg == ST_WAIT && state_next == ST_RUN) begin
					resume_out <= 1'b1;
					vector_out <= wake_vec;
				end
				if (state_reg == ST_STOP && state_next == ST_RECOV) begin
					// Latch now; the source may drop during recovery
					pend_vec_reg <= wake_vec;
				end
				if (state_reg == ST_RECOV && state_next == ST_RUN) begin
					resume_out <= 1'b1;
					vector_out <= pend_vec_reg;
				end
			end
		end
	end

	// AXI4-Lite write: address and data in either order
	// Only lane 0 carries control fields; status and vector ignore
	// writes but still answer OKAY
	assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
	wire aw_have = aw_hold_reg | (s_axi_awvalid & s_axi_awready);
	wire w_have = w_hold_reg | (s_axi_wvalid & s_axi_wready);
	wire [3:0] wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
	wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
	wire [3:0] ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			ctrl_reg <= `LPMC_CTRL_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (aw_have && w_have && !s_axi_bvalid) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				if (wa == `LPMC_CTRL_OFS) begin
					s_axi_bresp <= 2'b00;
					if (ws[0]) begin
						ctrl_reg <= wd[4:0];
					end
				end else if (wa == `LPMC_STAT_OFS || wa == `LPMC_VEC_OFS) begin
					s_axi_bresp <= 2'b00;
				end else begin
					s_axi_bresp <= 2'b10;
				end
			end else begin
				aw_hold_reg <= aw_have;
				w_hold_reg <= w_have;
			end
		end
	end

	// AXI4-Lite read
	assign s_axi_arready = !s_axi_rvalid;

	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			if (s_axi_araddr == `LPMC_CTRL_OFS) begin
				s_axi_rdata <= {27'h0000000, ctrl_reg};
			end else if (s_axi_araddr == `LPMC_STAT_OFS) begin
				s_axi_rdata <= {17'h00000, dly_reg, halt_mode_reg, state_reg};
			end else if (s_axi_araddr == `LPMC_VEC_OFS) begin
				s_axi_rdata <= {16'h0000, vector_out};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// [verif/low_power_mode_controller_tb.sv]
`timescale 1ns/1ns
module low_power_mode_controller_tb;
	reg clk_in = 1'b0;
	reg rstn_in = 1'b0;
	reg do_stop = 1'b0;
	reg do_wait = 1'b0;
	reg [6:0] src = 7'h00;
	reg [3:0] wake_port_pins_in = 4'h0;
	reg [3:0] s_axi_awaddr = 4'h0;
	reg [3:0] s_axi_araddr = 4'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg s_axi_awvalid = 1'b0;
	reg s_axi_wvalid = 1'b0;
	reg s_axi_bready = 1'b0;
	reg s_axi_arvalid = 1'b0;
	reg s_axi_rready = 1'b0;
	integer fails = 0;
	integer checked = 0;
	integer seed, i, n;
	reg [31:0] d;
	reg [1:0] r;
	reg [1:0] wr_resp = 2'b00;
	wire stop_req_in, wait_req_in, cpu_clk_en_out, resume_out;
	wire cpu_reset_out, irq_mask_clr_out, core_tick_clr_out;
	wire prog_timer_clr_out, ext_irq_enable_set_out, port_wake_en_out;
	wire internal_slow_osc_en_out, external_pin_osc_en_out;
	wire osc_use_external_out, periph_clk_en_out, watchdog_clk_en_out;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] vector_out, fetch;
	// Pins driven low by the set bits of src
	wire ext_irq_pin_in = ~src[0];
	wire reset_pin_in = ~src[6];
	always #5 clk_in = ~clk_in;
	lpmc_top i_lpmc_top (.clk_in, .rstn_in, .stop_req_in, .wait_req_in,
		.cpu_clk_en_out, .resume_out, .vector_out, .cpu_reset_out,
		.irq_mask_clr_out, .ext_irq_pin_in, .reset_pin_in,
		.wake_port_pins_in, .core_tick_irq_in(src[1]),
		.prog_timer_irq_in(src[2]), .serial_irq_in(src[3]),
		.analog_irq_in(src[4]), .watchdog_timeout_in(src[5]),
		.core_tick_clr_out, .prog_timer_clr_out, .ext_irq_enable_set_out,
		.internal_slow_osc_en_out, .external_pin_osc_en_out,
		.osc_use_external_out, .periph_clk_en_out, .watchdog_clk_en_out,
		.port_wake_en_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	lpmc_core_model i_lpmc_core_model (.clk_in, .rstn_in,
		.do_stop_in(do_stop), .do_wait_in(do_wait),
		.cpu_clk_en_in(cpu_clk_en_out), .resume_in(resume_out),
		.vector_in(vector_out), .stop_req_out(stop_req_in),
		.wait_req_out(wait_req_in), .fetch_out(fetch));
	// Expected oscillator enables {internal, external, use external}
	function [2:0] exp_osc(input [1:0] m);
		exp_osc = {m != 2'b01, m[0], m == 2'b01};
	endfunction
	// Expected wake vector per wait source
	function [15:0] exp_vec(input integer k);
		exp_vec = (k == 0) ? 16'h1ffa : 16'h1ffa - 2 * k;
	endfunction
	task wrap_up;
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task tmo(input integer k, input integer lim);
		if (k >= lim) begin
			fails = fails + 1;
			wrap_up;
		end
	endtask
	task cmp(input string what, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				fails = fails + 1;
				$display("mismatch %0s exp %0h got %0h", what, e, g);
			end
		end
	endtask
	task rng(input string what, input integer lo, hi, g);
		begin
			checked = checked + 1;
			if (g < lo || g > hi) begin
				fails = fails + 1;
				$display("mismatch %0s exp %0d..%0d got %0d", what, lo, hi, g);
			end
		end
	endtask
	// Register write, each channel released when taken
	task axw(input [3:0] a, input [31:0] v);
		integer k;
		begin
			@(posedge clk_in);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			k = 0;
			do begin
				@(posedge clk_in);
				k = k + 1;
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (s_axi_bvalid !== 1'b1 && k < 40);
			wr_resp = s_axi_bresp;
			s_axi_bready <= 1'b0;
			tmo(k, 40);
		end
	endtask
	task axr(input [3:0] a, output [31:0] v, output [1:0] e);
		integer k;
		begin
			@(posedge clk_in);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			k = 0;
			do begin
				@(posedge clk_in);
				k = k + 1;
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (s_axi_rvalid !== 1'b1 && k < 40);
			v = s_axi_rdata;
			e = s_axi_rresp;
			s_axi_rready <= 1'b0;
			tmo(k, 40);
		end
	endtask
	// Core model issues one instruction; returns in the first gated cycle
	task enter(input k);
		begin
			do_stop <= !k;
			do_wait <= k;
			@(posedge clk_in);
			do_stop <= 1'b0;
			do_wait <= 1'b0;
			repeat (2) @(posedge clk_in);
		end
	endtask
	// Count cycles until resume (k=0) or core reset (k=1)
	task wfor(input k, input integer lim, output integer c);
		begin
			c = 0;
			while ((k ? cpu_reset_out : resume_out) !== 1'b1 && c < lim) begin
				@(posedge clk_in);
				c = c + 1;
			end
			tmo(c, lim);
		end
	endtask
	task stop_run(input [4:0] c, input integer lo, hi);
		begin
			axw(4'h0, c);
			enter(1'b0);
			cmp("cpu clock", 0, cpu_clk_en_out);
			cmp("tick clear", !c[2], core_tick_clr_out);
			cmp("timer clear", !c[2], prog_timer_clr_out);
			cmp("watchdog clk", c[2], watchdog_clk_en_out);
			cmp("port wake", c[3], port_wake_en_out);
			repeat ($random(seed) & 7) @(posedge clk_in);
			if (c[3])
				wake_port_pins_in <= 4'h1 << ($random(seed) & 3);
			else
				src[0] <= 1'b1;
			wfor(1'b0, 5000, n);
			rng("recovery", lo, hi, n);
			@(posedge clk_in);
			cmp("stop vector", 16'h1ffa, fetch);
			src[0] <= 1'b0;
			wake_port_pins_in <= 4'h0;
			axr(4'h0, d, r);
			cmp("osc kept", c[1:0], d[1:0]);
		end
	endtask
	// Main sequence
	initial begin
		seed = 32'h825d;
		repeat (8) @(posedge clk_in);
		rstn_in <= 1'b1;
		axr(4'h0, d, r);
		cmp("ctrl reset", 32'h2, d);
		axr(4'hc, d, r);
		cmp("unmapped resp", 2'b10, r);
		cmp("unmapped data", 0, d);
		axw(4'hc, 32'h0);
		cmp("unmapped wresp", 2'b10, wr_resp);
		for (i = 0; i < 4; i = i + 1) begin
			axw(4'h0, i);
			cmp("write resp", 2'b00, wr_resp);
			cmp("osc", exp_osc(i), {internal_slow_osc_en_out,
				external_pin_osc_en_out, osc_use_external_out});
		end
		stop_run(5'h02, 16, 24);
		stop_run(5'h1a, 4064, 4072);
		stop_run(5'h06, 1, 24);
		// Halt wakes on a wait source too, after its recovery delay
		enter(1'b0);
		src[1] <= 1'b1;
		wfor(1'b0, 40, n);
		rng("halt wake", 1, 18, n);
		@(posedge clk_in);
		cmp("halt vector", exp_vec(1), fetch);
		src[1] <= 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			enter(1'b1);
			cmp("wait periph", 1, periph_clk_en_out);
			repeat ($random(seed) & 7) @(posedge clk_in);
			src[i] <= 1'b1;
			wfor(1'b0, 20, n);
			rng("wait exit", 1, i ? 2 : 8, n);
			@(posedge clk_in);
			cmp("wait vector", exp_vec(i), fetch);
			src[i] <= 1'b0;
		end
		enter(1'b1);
		src[5] <= 1'b1;
		wfor(1'b1, 20, n);
		src[5] <= 1'b0;
		@(posedge clk_in);
		cmp("watchdog vector", 16'h1ffe, fetch);
		axw(4'h0, 32'h2);
		enter(1'b0);
		src[6] <= 1'b1;
		wfor(1'b1, 20, n);
		src[6] <= 1'b0;
		repeat (4) @(posedge clk_in);
		cmp("reset vector", 16'h1ffe, vector_out);
		wrap_up;
	end
endmodule

// [verif/lpmc_chk_sva.sv]
`timescale 1ns/1ns
module lpmc_chk (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Core handshake
	input wire stop_req_in,
	input wire wait_req_in,
	input wire cpu_clk_en_out,
	input wire resume_out,
	input wire [15:0] vector_out,
	input wire cpu_reset_out,
	// Entry effects and clock gating
	input wire irq_mask_clr_out,
	input wire core_tick_clr_out,
	input wire prog_timer_clr_out,
	input wire ext_irq_enable_set_out,
	input wire internal_slow_osc_en_out,
	input wire external_pin_osc_en_out,
	input wire osc_use_external_out,
	input wire periph_clk_en_out,
	input wire watchdog_clk_en_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Entry effects of both low-power instructions
	chk_stop_entry: assert property (
		stop_req_in && cpu_clk_en_out |=> irq_mask_clr_out &&
		ext_irq_enable_set_out && !cpu_clk_en_out)
		else $error("stop entry effects missing");
	chk_wait_entry: assert property (
		wait_req_in && !stop_req_in && cpu_clk_en_out |=> irq_mask_clr_out
		&& ext_irq_enable_set_out && !core_tick_clr_out &&
		!prog_timer_clr_out && !cpu_clk_en_out && periph_clk_en_out)
		else $error("wait entry effects wrong");
	chk_stop_clear: assert property (
		core_tick_clr_out |-> prog_timer_clr_out && !periph_clk_en_out &&
		!watchdog_clk_en_out && $past(stop_req_in))
		else $error("timer clears out of place");
	// Oscillator and clock relations
	chk_osc_off: assert property (
		!internal_slow_osc_en_out && !external_pin_osc_en_out |->
		!periph_clk_en_out && !watchdog_clk_en_out)
		else $error("clock runs with oscillators off");
	chk_osc_select: assert property (
		osc_use_external_out && internal_slow_osc_en_out |-> 1'b0)
		else $error("external selected with internal on");
	// Resume handshake
	chk_resume_run: assert property (
		resume_out |-> cpu_clk_en_out && !$past(cpu_clk_en_out))
		else $error("resume without clock restart");
	chk_resume_pulse: assert property (
		resume_out |=> !resume_out)
		else $error("resume longer than one cycle");
	chk_vec_valid: assert property (
		resume_out |-> vector_out inside {16'h1ffe, 16'h1ffa, 16'h1ff8,
		16'h1ff6, 16'h1ff4, 16'h1ff2})
		else $error("resume with unknown vector");
	// Reset and true stop gating
	chk_reset_vector: assert property (
		cpu_reset_out |-> vector_out == 16'h1ffe && cpu_clk_en_out)
		else $error("core reset without reset vector");
	chk_stop_clocks: assert property (
		!periph_clk_en_out |-> !internal_slow_osc_en_out &&
		!external_pin_osc_en_out && !cpu_clk_en_out && !watchdog_clk_en_out)
		else $error("clock left running in stop");
endmodule
bind lpmc_top lpmc_chk i_lpmc_chk (.clk_in, .rstn_in, .stop_req_in,
	.wait_req_in, .cpu_clk_en_out, .resume_out, .vector_out, .cpu_reset_out,
	.irq_mask_clr_out, .core_tick_clr_out, .prog_timer_clr_out,
	.ext_irq_enable_set_out, .internal_slow_osc_en_out,
	.external_pin_osc_en_out, .osc_use_external_out, .periph_clk_en_out,
	.watchdog_clk_en_out);

// [verif/lpmc_core_model.sv]
`timescale 1ns/1ns
module lpmc_core_model (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Bench commands and controller side
	input wire do_stop_in,
	input wire do_wait_in,
	input wire cpu_clk_en_in,
	input wire resume_in,
	input wire [15:0] vector_in,
	// Instruction pulses and fetched vector
	output reg stop_req_out,
	output reg wait_req_out,
	output reg [15:0] fetch_out
);
	// Instructions issue only while the bus clock runs; fetch on resume
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stop_req_out <= 1'b0;
			wait_req_out <= 1'b0;
			fetch_out <= 16'h0000;
		end else begin
			stop_req_out <= do_stop_in & cpu_clk_en_in;
			wait_req_out <= do_wait_in & cpu_clk_en_in;
			if (resume_in)
				fetch_out <= vector_in;
		end
	end
endmodule
